// ==== design/opg_sequencer.sv ====
// programmer side sequencer for a 64K x 8 one-time-programmable eprom
// assumes data_in and src_data are synchronous to clk; supply outputs
// are commands to external regulators and an id voltage switch on address line nine
//
// What this block does
// - chip select pulse is held low for the nominal 100 us program pulse width
// - address starts at zero; core 6.5 V and program supply 13 V before pulses
// - first pass gives every address one pulse with no verify between
// - second pass verifies each byte; mismatch gets up to ten pulses, verify each
// - still mismatching after ten extra pulses: whole part failed, sequence ends
// - verified byte advances address; loop repeats until every address is checked
// - after last address pin goes low, core to 5.0 V, reread from zero until first mismatch or last address, report
// - core supply up before program supply and withdrawn after it
// - after chip select rises wait 130 ns float delay before driving data
// - program and verify timing leaves room for output enable and float delays
// - id select line at id voltage: maker code with lowest line low, part code high
module opg_sequencer
  import opg_pkg::*;
#(
  parameter int AW     = 16,
  parameter int DW     = 8,
  parameter int PW_CYC = PW_CYC_DEF
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic          start,
  input  wire logic          id_start,
  input  wire logic [DW-1:0] src_data,
  input  wire logic [DW-1:0] data_in,
  output logic      [AW-1:0] addr_out,
  output logic      [DW-1:0] data_out,
  output logic               data_oe,
  output logic               chip_sel_n,
  output logic               oe_level,
  output logic               vpp_on,
  output logic               vcc_on,
  output logic               vcc_prog,
  output logic               id_voltage_on,
  output logic               busy,
  output logic               done,
  output logic               pass,
  output logic               fail,
  output logic      [AW-1:0] fail_addr,
  output logic      [3:0]    retry_cnt,
  output logic               id_valid,
  output logic      [DW-1:0] id_maker,
  output logic      [DW-1:0] id_part
);
  localparam logic [TMR_W-1:0] PW_LOAD   = TMR_W'(PW_CYC - 1);
  localparam logic [AW-1:0]    ADDR_LAST = {AW{1'b1}};
  opg_state_t             state_r;
  opg_phase_t             phase_r;
  logic       [TMR_W-1:0] tmr_r;
  logic                   match_r;
  logic                   expired;
  logic                   last;
  assign expired = (tmr_r == '0);
  assign last    = (addr_out == ADDR_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // sequence control, pin drive and status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r       <= ST_IDLE;
      phase_r       <= PH_FIRST;
      tmr_r         <= '0;
      match_r       <= 1'b0;
      addr_out      <= '0;
      data_out      <= '0;
      data_oe       <= 1'b0;
      chip_sel_n    <= 1'b1;
      oe_level      <= 1'b1;
      vpp_on        <= 1'b0;
      vcc_on        <= 1'b0;
      vcc_prog      <= 1'b0;
      id_voltage_on <= 1'b0;
      busy          <= 1'b0;
      done          <= 1'b0;
      pass          <= 1'b0;
      fail          <= 1'b0;
      fail_addr     <= '0;
      retry_cnt     <= 4'h0;
      id_valid      <= 1'b0;
      id_maker      <= '0;
      id_part       <= '0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (!expired) begin
        tmr_r <= tmr_r - TMR_W'(1);
      end
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            addr_out  <= '0;
            phase_r   <= PH_FIRST;
            vcc_on    <= 1'b1;
            vcc_prog  <= 1'b1;
            busy      <= 1'b1;
            pass      <= 1'b0;
            fail      <= 1'b0;
            retry_cnt <= 4'h0;
            tmr_r     <= SU_LOAD;
            state_r   <= ST_VCC_UP;
          end else if (id_start) begin
            addr_out      <= '0;
            phase_r       <= PH_ID;
            vcc_on        <= 1'b1;
            vcc_prog      <= 1'b0;
            id_voltage_on <= 1'b1;
            busy          <= 1'b1;
            id_valid      <= 1'b0;
            tmr_r         <= SU_LOAD;
            state_r       <= ST_VCC_UP;
          end
        end
        ST_VCC_UP: begin
          if (expired) begin
            if (phase_r == PH_ID) begin
              oe_level   <= 1'b0;
              chip_sel_n <= 1'b0;
              tmr_r      <= DV_LOAD;
              state_r    <= ST_READ;
            end else begin
              vpp_on  <= 1'b1;
              tmr_r   <= SU_LOAD;
              state_r <= ST_VPP_UP;
            end
          end
        end
        ST_VPP_UP: begin
          if (expired) begin
            data_oe <= 1'b1;
            tmr_r   <= SU_LOAD;
            state_r <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          data_out <= src_data;
          if (expired) begin
            chip_sel_n <= 1'b0;
            tmr_r      <= PW_LOAD;
            state_r    <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (expired) begin
            chip_sel_n <= 1'b1;
            tmr_r      <= SU_LOAD;
            state_r    <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (expired) begin
            if (phase_r == PH_FIRST && !last) begin
              addr_out <= addr_out + AW'(1);
              tmr_r    <= SU_LOAD;
              state_r  <= ST_SETUP;
            end else begin
              if (phase_r == PH_FIRST) begin
                phase_r  <= PH_VERIFY;
                addr_out <= '0;
              end
              data_oe <= 1'b0;
              vpp_on  <= 1'b0;
              tmr_r   <= SU_LOAD;
              state_r <= ST_VPP_OFF;
            end
          end
        end
        ST_VPP_OFF: begin
          if (expired) begin
            oe_level   <= 1'b0;
            chip_sel_n <= 1'b0;
            tmr_r      <= DV_LOAD;
            state_r    <= ST_READ;
          end
        end
        ST_READ: begin
          if (expired) begin
            if (phase_r == PH_ID) begin
              if (addr_out[0]) begin
                id_part <= data_in;
              end else begin
                id_maker <= data_in;
              end
            end
            match_r    <= (data_in == src_data);
            chip_sel_n <= 1'b1;
            oe_level   <= 1'b1;
            tmr_r      <= DFP_LOAD;
            state_r    <= ST_FLOAT;
          end
        end
        ST_FLOAT: begin
          if (expired) begin
            case (phase_r)
              PH_ID: begin
                if (!addr_out[0]) begin
                  addr_out   <= AW'(1);
                  oe_level   <= 1'b0;
                  chip_sel_n <= 1'b0;
                  tmr_r      <= DV_LOAD;
                  state_r    <= ST_READ;
                end else begin
                  id_voltage_on <= 1'b0;
                  id_valid      <= 1'b1;
                  state_r       <= ST_END;
                end
              end
              PH_VERIFY: begin
                if (match_r) begin
                  retry_cnt <= 4'h0;
                  if (last) begin
                    oe_level <= 1'b0;
                    tmr_r    <= SU_LOAD;
                    state_r  <= ST_DOWN;
                  end else begin
                    addr_out   <= addr_out + AW'(1);
                    oe_level   <= 1'b0;
                    chip_sel_n <= 1'b0;
                    tmr_r      <= DV_LOAD;
                    state_r    <= ST_READ;
                  end
                end else if (retry_cnt == RETRY_MAX) begin
                  fail      <= 1'b1;
                  fail_addr <= addr_out;
                  oe_level  <= 1'b0;
                  tmr_r     <= SU_LOAD;
                  state_r   <= ST_DOWN;
                end else begin
                  retry_cnt <= retry_cnt + 4'h1;
                  vpp_on    <= 1'b1;
                  tmr_r     <= SU_LOAD;
                  state_r   <= ST_VPP_UP;
                end
              end
              PH_FINAL: begin
                if (!match_r) begin
                  fail      <= 1'b1;
                  fail_addr <= addr_out;
                  state_r   <= ST_END;
                end else if (last) begin
                  pass    <= 1'b1;
                  state_r <= ST_END;
                end else begin
                  addr_out   <= addr_out + AW'(1);
                  oe_level   <= 1'b0;
                  chip_sel_n <= 1'b0;
                  tmr_r      <= DV_LOAD;
                  state_r    <= ST_READ;
                end
              end
              default: begin
                state_r <= ST_END;
              end
            endcase
          end
        end
        ST_DOWN: begin
          if (expired) begin
            vcc_prog <= 1'b0;
            tmr_r    <= SU_LOAD;
            state_r  <= ST_VCC_LO;
          end
        end
        ST_VCC_LO: begin
          if (expired) begin
            if (fail) begin
              state_r <= ST_END;
            end else begin
              phase_r    <= PH_FINAL;
              addr_out   <= '0;
              chip_sel_n <= 1'b0;
              tmr_r      <= DV_LOAD;
              state_r    <= ST_READ;
            end
          end
        end
        ST_END: begin
          vpp_on        <= 1'b0;
          vcc_on        <= 1'b0;
          vcc_prog      <= 1'b0;
          id_voltage_on <= 1'b0;
          chip_sel_n    <= 1'b1;
          oe_level      <= 1'b1;
          data_oe       <= 1'b0;
          busy          <= 1'b0;
          done          <= 1'b1;
          state_r       <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== design/opg_pkg.sv ====
// constants and types for the byte programming sequencer
// assumes a 125 MHz clock; all device pin timing is counted in clk cycles
package opg_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // pin timing in nanoseconds
  localparam int T_PW_NOM_NS = 100000;
  localparam int T_PW_MIN_NS = 95000;
  localparam int T_PW_MAX_NS = 105000;
  localparam int T_SETUP_NS  = 2000;
  localparam int T_DV_NS     = 1000;
  localparam int T_DFP_NS    = 130;

  // cycle counts: least times round up
  localparam int PW_CYC_DEF = (T_PW_NOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PW_CYC_MIN = (T_PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PW_CYC_MAX = T_PW_MAX_NS / CLK_PERIOD_NS;
  localparam int SU_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DV_CYC     = (T_DV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DFP_CYC    = (T_DFP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TMR_W = 24;

  localparam logic [TMR_W-1:0] SU_LOAD  = TMR_W'(SU_CYC - 1);
  localparam logic [TMR_W-1:0] DV_LOAD  = TMR_W'(DV_CYC - 1);
  localparam logic [TMR_W-1:0] DFP_LOAD = TMR_W'(DFP_CYC - 1);

  // extra pulses allowed per byte in the verify pass
  localparam logic [3:0] RETRY_MAX = 4'ha;

  typedef enum logic [1:0] {
    PH_FIRST,
    PH_VERIFY,
    PH_FINAL,
    PH_ID
  } opg_phase_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_VCC_UP,
    ST_VPP_UP,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_VPP_OFF,
    ST_READ,
    ST_FLOAT,
    ST_DOWN,
    ST_VCC_LO,
    ST_END
  } opg_state_t;

endpackage

// ==== bench/opg_checker.sv ====
// checker: timing relations between the sequencer pins
// assumes a bind onto opg_sequencer; counts are clk cycles
module opg_checker
  import opg_pkg::*;
#(
  parameter int PW_CYC = 20
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       chip_sel_n,
  input wire logic       oe_level,
  input wire logic       data_oe,
  input wire logic       vpp_on,
  input wire logic       vcc_on,
  input wire logic       vcc_prog,
  input wire logic       id_voltage_on,
  input wire logic       done,
  input wire logic [3:0] retry_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int lo_cnt_r;
  int hi_cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_cnt_r <= 0;
      hi_cnt_r <= 1000;
    end else begin
      lo_cnt_r <= chip_sel_n ? 0 : lo_cnt_r + 1;
      hi_cnt_r <= !chip_sel_n ? 0 : (hi_cnt_r < 1000 ? hi_cnt_r + 1 : hi_cnt_r);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_prog_end;
    $rose(chip_sel_n) && vpp_on;
  endsequence
  sequence s_read_end;
    $rose(chip_sel_n) && !vpp_on;
  endsequence
  property p_pulse;
    s_prog_end |-> lo_cnt_r == PW_CYC;
  endproperty
  property p_read;
    s_read_end |-> lo_cnt_r == DV_CYC;
  endproperty
  property p_supply;
    $fell(chip_sel_n) && vpp_on |-> vcc_on && vcc_prog;
  endproperty
  property p_order;
    vpp_on |-> vcc_on;
  endproperty
  property p_float;
    $rose(data_oe) |-> hi_cnt_r >= DFP_CYC;
  endproperty
  property p_final;
    vcc_on && !vcc_prog |-> !vpp_on;
  endproperty
  property p_retry;
    $changed(retry_cnt) && retry_cnt != 0 |->
      retry_cnt == $past(retry_cnt) + 1 && retry_cnt <= RETRY_MAX;
  endproperty
  property p_id;
    id_voltage_on |-> vcc_on && !vcc_prog && !vpp_on;
  endproperty
  property p_done;
    done |=> !done;
  endproperty
  property p_read_oe;
    !chip_sel_n && !vpp_on |-> !oe_level;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width wrong");
  a_read: assert property (p_read) else $error("read length wrong");
  a_supply: assert property (p_supply) else $error("supply low at pulse");
  a_order: assert property (p_order) else $error("vpp without vcc");
  a_float: assert property (p_float) else $error("data driven too soon");
  a_final: assert property (p_final) else $error("vpp at 5 V core");
  a_retry: assert property (p_retry) else $error("retry count step");
  a_id: assert property (p_id) else $error("id levels wrong");
  a_done: assert property (p_done) else $error("done too long");
  a_read_oe: assert property (p_read_oe) else $error("output gate high in read");
endmodule

// ==== bench/opg_eprom_model.sv ====
// eprom model: and-programmed byte array, timed reads, id codes
// assumes pin commands from the sequencer; data lines resolved by the bench
module opg_eprom_model #(
  parameter int         AW    = 2,
  parameter logic [7:0] MAKER = 8'h5c,  // arbitrary
  parameter logic [7:0] PART  = 8'ha3   // arbitrary
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    din,
  input  wire logic          cs_n,
  input  wire logic          oe_lvl,
  input  wire logic          vpp,
  input  wire logic          id_hv,
  input  wire logic [AW-1:0] weak_addr,
  input  wire logic [4:0]    weak_need,
  output logic      [7:0]    dq,
  output logic               dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem  [2**AW];
  logic [4:0] hits [2**AW];
  int         lo;
  assign dq    = id_hv ? (addr[0] ? PART : MAKER) : mem[addr];
  assign dq_oe = !cs_n && !oe_lvl && !vpp && lo > 4;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem[i] <= 8'hff;
        hits[i] <= 5'h00;
      end
      lo <= 0;
    end else begin
      lo <= cs_n ? 0 : lo + 1;
      if (cs_n && lo > 0 && vpp) begin
        hits[addr] <= hits[addr] + 5'h01;
        if (hits[addr] + 5'h01 >= ((addr == weak_addr) ? weak_need : 5'h01))
          mem[addr] <= mem[addr] & din;
      end
    end
  end
endmodule

// ==== bench/tb_top.sv ====
// top bench: sequencer driving the eprom model, id and program runs
// assumes design package, sequencer, model and checker compiled before
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       rst = 1'h1;
  logic       start = 1'h0;
  logic       id_start = 1'h0;
  logic       clk_en = 1'h1;
  logic [1:0] addr_out, fail_addr, weak_addr = 2'h0;
  logic [4:0] weak_need = 5'h01;
  logic [7:0] src_data, data_in, data_out, dq, id_maker, id_part, last_r = 8'h00;
  logic [3:0] retry_cnt;
  logic       data_oe, chip_sel_n, oe_level, vpp_on, vcc_on, vcc_prog, dq_oe;
  logic       id_voltage_on, busy, done, pass, fail, id_valid;
  int         bad_count = 0;
  int         comparisons = 0;
  assign src_data = 8'h35 ^ {6'h00, addr_out};
  assign data_in  = data_oe ? data_out : (dq_oe ? dq : ~last_r);
  always @(posedge clk) last_r <= data_in;
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  opg_sequencer #(.AW(2), .PW_CYC(20)) u_opg_sequencer (
    .clk, .rst, .clk_en, .start, .id_start, .src_data, .data_in, .addr_out,
    .data_out, .data_oe, .chip_sel_n, .oe_level, .vpp_on, .vcc_on, .vcc_prog,
    .id_voltage_on, .busy, .done, .pass, .fail, .fail_addr, .retry_cnt, .id_valid,
    .id_maker, .id_part
  );
  opg_eprom_model #(.AW(2)) u_opg_eprom_model (
    .clk, .rst, .addr(addr_out), .din(data_in), .cs_n(chip_sel_n), .oe_lvl(oe_level),
    .vpp(vpp_on), .id_hv(id_voltage_on), .weak_addr, .weak_need, .dq, .dq_oe
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_f(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t value %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'h1) begin
      @(negedge clk);
      n++;
      if (n > 40000) begin
        bad_count++;
        final_report;
      end
    end
    chk_f(busy, 1'h0);
  endtask
  task automatic kick(input logic id);
    @(negedge clk);
    if (id) id_start = 1'h1;
    else start = 1'h1;
    @(negedge clk);
    start = 1'h0;
    id_start = 1'h0;
    chk_f(busy, 1'h1);
    wait_done;
  endtask
  task automatic do_reset;
    rst = 1'h1;
    repeat (20) @(negedge clk);
    chk_f(vpp_on, 1'h0);
    chk_f(chip_sel_n, 1'h1);
    rst = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_id;
    do_reset;
    kick(1'h1);
    chk_f(id_valid, 1'h1);
    chk_v(id_maker, 8'h5c);
    chk_v(id_part, 8'ha3);
  endtask
  task automatic t_freeze;
    do_reset;
    @(negedge clk);
    id_start = 1'h1;
    @(negedge clk);
    id_start = 1'h0;
    clk_en = 1'h0;
    repeat (300) @(negedge clk);
    chk_f(chip_sel_n, 1'h1);
    chk_f(id_valid, 1'h0);
    chk_f(busy, 1'h1);
    clk_en = 1'h1;
    wait_done;
    chk_f(id_valid, 1'h1);
    chk_v(id_part, 8'ha3);
  endtask
  task automatic t_prog(input logic [1:0] wa, input logic [4:0] need, input logic ok);
    weak_addr = wa;
    weak_need = need;
    do_reset;
    kick(1'h0);
    chk_f(pass, ok);
    chk_f(fail, !ok);
    if (!ok) chk_v({6'h00, fail_addr}, {6'h00, wa});
    chk_v({3'h0, u_opg_eprom_model.hits[wa]}, ok ? {3'h0, need} : 8'h0b);
    for (int i = 0; i < 4; i++) begin
      if (ok) chk_v(u_opg_eprom_model.mem[i], 8'h35 ^ 8'(i));
      if (i != wa) chk_v({3'h0, u_opg_eprom_model.hits[i]}, 8'h01);
    end
  endtask
  initial begin
    t_id;
    t_freeze;
    t_prog(2'h2, 5'h04, 1'h1);
    t_prog(2'h1, 5'h0b, 1'h1);
    t_prog(2'h3, 5'h0c, 1'h0);
    final_report;
  end
endmodule
bind opg_sequencer opg_checker #(.PW_CYC(PW_CYC)) u_opg_checker (
  .clk, .rst, .chip_sel_n, .data_oe, .vpp_on, .vcc_on, .vcc_prog, .id_voltage_on,
  .done, .retry_cnt, .oe_level
);
